// file: uis_pkg.sv
// Shared constants and carrier types for the serial controller interrupt and status block
package uis_pkg;

    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int LEVEL_W = 5;
    localparam int GAP_W = 8;
    localparam int TOUT_W = 8;
    localparam int BAUD_W = 16;
    localparam int FUNSEL_W = 2;
    localparam logic [1:0] FUNSEL_UART = 2'h0;
    localparam logic [1:0] FUNSEL_LIN = 2'h1;
    localparam logic [1:0] FUNSEL_IRDA = 2'h2;
    localparam logic [1:0] FUNSEL_RS485 = 2'h3;
    localparam logic [15:0] BAUD_DIV_RESET = 16'h0013;
    localparam int CLK_HZ = 40000000;
    localparam int MAX_BPS = 1000000;
    // Shortest legal bit period in clocks at the top bit rate
    localparam int MIN_BIT_CLKS = (CLK_HZ + MAX_BPS - 1) / MAX_BPS;
    localparam logic [7:0] GAP_RESET = 8'h00;
    localparam logic [7:0] TOUT_RESET = 8'h00;
    localparam logic [4:0] RX_TRIG_RESET = 5'h01;
    localparam logic [4:0] RTS_LEV_RESET = 5'h0e;

    // Line status sources in receive order
    typedef struct packed {
        logic breakSeen;
        logic framingError;
        logic parityError;
        logic addrMatch;
    } uis_line_t;

    typedef struct packed {
        logic linBreak;
        logic bitError;
        logic idParity;
        logic headerError;
        logic headerSeen;
    } uis_lin_t;

    // One bit per interrupt source
    typedef struct packed {
        logic rxAvail;
        logic txEmpty;
        logic lineStatus;
        logic modemWake;
        logic rxTimeout;
        logic overflow;
        logic linBus;
    } uis_src_t;

endpackage

// file: uis_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module uis_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int CNT_W = $clog2(DEPTH + 1)
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [CNT_W-1:0] level
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wrPtr_q;
    logic [PTR_W-1:0] rdPtr_q;
    logic [CNT_W-1:0] count_q;
    wire push = inValid && inReady;
    wire pop = outValid && outReady;
    wire [PTR_W-1:0] wrNext = (wrPtr_q == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_q + PTR_W'(1);
    wire [PTR_W-1:0] rdNext = (rdPtr_q == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_q + PTR_W'(1);

    assign inReady = count_q != CNT_W'(DEPTH);
    assign outValid = count_q != '0;
    assign outData = mem_q[rdPtr_q];
    assign level = count_q;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
                wrPtr_q <= wrNext;
            if (pop)
                rdPtr_q <= rdNext;
            count_q <= count_q + CNT_W'(push) - CNT_W'(pop);
        end
    end
endmodule

// file: uis_uart.sv
// UART function mode with interrupt flags, DMA flag set and CTS/RTS flow control
// What this block does
// - Indicator high only when flag and enable set
// - Receive-available set at trigger, cleared on read
// - Transmit-empty set when FIFO empties, cleared by write
// - Line status flags clear by write one each
// - Modem flag follows CTS change, write-one clear
// - Timeout set on receive idle, cleared on read
// - Transmit overflow clears by write one
// - Receive overflow clears by write one
// - LIN break clear needs both flags written
// - LIN bit error drives LIN flag, write-one clear
// - LIN ID parity error, write-one clear
// - LIN slave header error, write-one clear
// - LIN header seen, write-one clear
// - DMA mode uses separate hardware flag set
// - Function select zero means UART mode
// - Bit rate up to one megabit
// - Full duplex, 16-byte FIFOs each way
// - Programmable receive trigger and timeout
// - Eight-bit idle gap between transmitted characters
// - RTS withdrawn at programmable receive level
// - Gap counted in whole bit periods
`timescale 1ns/1ps
module uis_uart #(
    parameter int DATA_W = uis_pkg::DATA_W,
    parameter int FIFO_DEPTH = uis_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [1:0] functionSelect,
    input wire logic [15:0] baudDiv,
    input wire logic [7:0] txGapDelay,
    input wire logic [7:0] timeoutDelay,
    input wire logic [4:0] rxTrigLevel,
    input wire logic [4:0] rtsLevel,
    input wire logic autoRtsEn,
    input wire logic autoCtsEn,
    input wire logic dmaMode,
    input wire uis_pkg::uis_src_t irqEnable,
    input wire logic txWrite,
    input wire logic [7:0] txWrData,
    output logic txReady,
    input wire logic rxRead,
    output logic [7:0] rxBufferReg,
    output logic rxDataValid,
    input wire uis_pkg::uis_line_t lineClear,
    input wire logic ctsChangeClear,
    input wire logic txOverClear,
    input wire logic rxOverClear,
    input wire logic linIrqClear,
    input wire uis_pkg::uis_lin_t linClear,
    input wire logic dmaFlagClearBit,
    input wire logic rs485AddrEvent,
    input wire uis_pkg::uis_lin_t linEvent,
    output uis_pkg::uis_src_t irqFlag,
    output uis_pkg::uis_line_t lineFlag,
    output uis_pkg::uis_lin_t linFlag,
    output logic txOverFlag,
    output logic rxOverFlag,
    output logic linIrqFlag,
    output uis_pkg::uis_src_t irqIndicator,
    output logic irq,
    output logic [4:0] rxLevel,
    output logic [4:0] txLevel,
    input wire logic rxd,
    output logic txd,
    input wire logic ctsIn,
    output logic rtsOut
);
    // Pin synchronisers
    logic rxdMeta_q;
    logic rxdSync_q;
    logic ctsMeta_q;
    logic ctsSync_q;
    logic ctsLast_q;
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rxdMeta_q <= 1'b1;
            rxdSync_q <= 1'b1;
        end
        else
        begin
            rxdMeta_q <= rxd;
            rxdSync_q <= rxdMeta_q;
        end
    end

    // CTS chain runs through reset, so a pin that already stands high
    // gives no false change event once reset is released
    always_ff @(posedge clk)
    begin
        ctsMeta_q <= ctsIn;
        ctsSync_q <= ctsMeta_q;
        ctsLast_q <= ctsSync_q;
    end

    wire uartMode = functionSelect == uis_pkg::FUNSEL_UART;
    // Divider floor keeps the rate at or below the top bit rate
    wire [15:0] minDiv = 16'(uis_pkg::MIN_BIT_CLKS / 16);
    wire [15:0] divUse = (baudDiv < minDiv) ? minDiv : baudDiv;
    logic [15:0] tickCnt_q;
    wire tick16 = tickCnt_q == 16'h0000;
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            tickCnt_q <= 16'h0000;
        else
            tickCnt_q <= tick16 ? divUse : tickCnt_q - 16'h0001;
    end

    // Transmit FIFO, then shifter; separate from receive so both run at once
    logic txOutValid;
    logic txPop;
    logic txInReady;
    logic [7:0] txHead;
    uis_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) txFifo (
        .clk(clk),
        .rst_b(rst_b),
        .inValid(txWrite),
        .inReady(txInReady),
        .inData(txWrData),
        .outValid(txOutValid),
        .outReady(txPop),
        .outData(txHead),
        .level(txLevel)
    );
    assign txReady = txInReady;
    wire txOverEvent = txWrite && !txInReady;

    logic [3:0] txSub_q;
    logic [3:0] txBit_q;
    logic [9:0] txShift_q;
    logic txBusy_q;
    logic [7:0] gapCnt_q;
    wire ctsOk = !autoCtsEn || ctsSync_q;
    wire txBitEnd = txBusy_q && tick16 && txSub_q == 4'hf;
    wire gapBitEnd = !txBusy_q && gapCnt_q != 8'h00 && tick16 && txSub_q == 4'hf;
    assign txPop = !txBusy_q && txOutValid && gapCnt_q == 8'h00 && ctsOk && uartMode;
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            txBusy_q <= 1'b0;
            txSub_q <= 4'h0;
            txBit_q <= 4'h0;
            txShift_q <= 10'h3ff;
            gapCnt_q <= uis_pkg::GAP_RESET;
        end
        else
        begin
            if (tick16)
                txSub_q <= txSub_q + 4'h1;
            if (txPop)
            begin
                txBusy_q <= 1'b1;
                txShift_q <= {1'b1, txHead, 1'b0};
                txBit_q <= 4'h0;
                txSub_q <= 4'h0;
            end
            else if (txBitEnd)
            begin
                txShift_q <= {1'b1, txShift_q[9:1]};
                txBit_q <= txBit_q + 4'h1;
                if (txBit_q == 4'h9)
                begin
                    txBusy_q <= 1'b0;
                    gapCnt_q <= txGapDelay;
                end
            end
            else if (gapBitEnd)
                gapCnt_q <= gapCnt_q - 8'h01;
        end
    end
    assign txd = txShift_q[0];

    // Receiver sampling at mid-bit
    logic rxBusy_q;
    logic [3:0] rxSub_q;
    logic [3:0] rxBit_q;
    logic [7:0] rxShift_q;
    wire rxSample = rxBusy_q && tick16 && rxSub_q == 4'h7;
    wire rxStop = rxSample && rxBit_q == 4'h9;
    wire rxFramingEvent = rxStop && !rxdSync_q;
    wire rxBreakEvent = rxFramingEvent && rxShift_q == 8'h00;
    logic rxInReady;
    logic rxOutValid;
    wire rxOverEvent = rxStop && rxdSync_q && !rxInReady;
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rxBusy_q <= 1'b0;
            rxSub_q <= 4'h0;
            rxBit_q <= 4'h0;
            rxShift_q <= 8'h00;
        end
        else
        begin
            if (tick16)
                rxSub_q <= rxSub_q + 4'h1;
            if (!rxBusy_q && !rxdSync_q && uartMode)
            begin
                rxBusy_q <= 1'b1;
                rxSub_q <= 4'h0;
                rxBit_q <= 4'h0;
            end
            else if (rxSample)
            begin
                rxBit_q <= rxBit_q + 4'h1;
                if (rxBit_q == 4'h0 && rxdSync_q)
                    rxBusy_q <= 1'b0;
                else if (rxBit_q != 4'h0 && rxBit_q != 4'h9)
                    rxShift_q <= {rxdSync_q, rxShift_q[7:1]};
                if (rxStop)
                    rxBusy_q <= 1'b0;
            end
        end
    end

    uis_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) rxFifo (
        .clk(clk),
        .rst_b(rst_b),
        .inValid(rxStop && rxdSync_q),
        .inReady(rxInReady),
        .inData(rxShift_q),
        .outValid(rxOutValid),
        .outReady(rxRead),
        .outData(rxBufferReg),
        .level(rxLevel)
    );
    assign rxDataValid = rxOutValid;

    // RTS drops once the receive FIFO holds the programmed count
    logic rts_q;
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            rts_q <= 1'b0;
        else
            rts_q <= !autoRtsEn || rxLevel < rtsLevel;
    end
    assign rtsOut = rts_q;

    // Receive idle timer, counted in bit periods while data waits
    logic [7:0] toutCnt_q;
    wire bitTick = tick16 && rxSub_q == 4'hf;
    wire toutEvent = rxOutValid && !rxBusy_q && bitTick && toutCnt_q == timeoutDelay
        && timeoutDelay != 8'h00;
    always_ff @(posedge clk)
    begin
        if (!rst_b || rxRead || rxBusy_q || !rxOutValid)
            toutCnt_q <= 8'h00;
        else if (bitTick && toutCnt_q != timeoutDelay)
            toutCnt_q <= toutCnt_q + 8'h01;
    end

    // Receive level at or above trigger and transmit-empty crossing become set events
    wire rxAvailLevel = rxLevel >= rxTrigLevel && rxTrigLevel != 5'h00;
    logic txEmptyLast_q;
    wire txEmptyEvent = txLevel == 5'h00 && !txEmptyLast_q;
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            txEmptyLast_q <= 1'b1;
        else
            txEmptyLast_q <= txLevel == 5'h00;
    end

    // Sticky flags: a set in the clearing cycle wins
    uis_pkg::uis_line_t line_q;
    uis_pkg::uis_lin_t lin_q;
    logic rxAvail_q;
    logic txEmpty_q;
    logic ctsChange_q;
    logic tout_q;
    logic txOver_q;
    logic rxOver_q;
    logic linIf_q;
    logic dmaLine_q;
    logic dmaOver_q;
    wire uis_pkg::uis_line_t lineSet = '{breakSeen: rxBreakEvent, framingError: rxFramingEvent,
        parityError: 1'b0, addrMatch: rs485AddrEvent};
    wire ctsEvent = ctsSync_q != ctsLast_q;
    wire lineAny = |lineSet;
    wire overAny = txOverEvent || rxOverEvent;
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            line_q <= '0;
            lin_q <= '0;
            rxAvail_q <= 1'b0;
            txEmpty_q <= 1'b0;
            ctsChange_q <= 1'b0;
            tout_q <= 1'b0;
            txOver_q <= 1'b0;
            rxOver_q <= 1'b0;
            linIf_q <= 1'b0;
            dmaLine_q <= 1'b0;
            dmaOver_q <= 1'b0;
        end
        else
        begin
            rxAvail_q <= rxAvailLevel || (rxAvail_q && !rxRead);
            txEmpty_q <= txEmptyEvent || (txEmpty_q && !txWrite);
            line_q <= lineSet | (line_q & ~lineClear);
            ctsChange_q <= ctsEvent || (ctsChange_q && !ctsChangeClear);
            tout_q <= toutEvent || (tout_q && !rxRead);
            txOver_q <= txOverEvent || (txOver_q && !txOverClear);
            rxOver_q <= rxOverEvent || (rxOver_q && !rxOverClear);
            lin_q <= linEvent | (lin_q & ~linClear);
            // Break alone keeps the summary set until its own clear is paired
            linIf_q <= linEvent.linBreak || (linIf_q && !(linIrqClear && linClear.linBreak));
            dmaLine_q <= lineAny || (dmaLine_q && !dmaFlagClearBit);
            dmaOver_q <= overAny || (dmaOver_q && !dmaFlagClearBit);
        end
    end

    // Non-break LIN causes drive the summary directly from their flags
    wire linSummary = linIf_q || lin_q.bitError || lin_q.idParity || lin_q.headerError
        || lin_q.headerSeen;
    assign irqFlag = '{
        rxAvail: rxAvail_q,
        txEmpty: txEmpty_q,
        lineStatus: dmaMode ? dmaLine_q : |line_q,
        modemWake: ctsChange_q,
        rxTimeout: tout_q,
        overflow: dmaMode ? dmaOver_q : (txOver_q || rxOver_q),
        linBus: linSummary};
    assign lineFlag = line_q;
    assign linFlag = lin_q;
    assign txOverFlag = txOver_q;
    assign rxOverFlag = rxOver_q;
    assign linIrqFlag = linIf_q;
    assign irqIndicator = irqFlag & irqEnable;
    assign irq = |irqIndicator;
endmodule

// file: uis_uart_sva.sv
// Checker for interrupt flags, the combined request and RTS withdrawal
`timescale 1ns/1ps
module uis_uart_sva (
    input wire logic clk,
    input wire logic rst_b,
    input wire uis_pkg::uis_src_t irqEnable,
    input wire logic txWrite,
    input wire logic txReady,
    input wire logic rxRead,
    input wire logic txOverClear,
    input wire logic linIrqClear,
    input wire uis_pkg::uis_lin_t linClear,
    input wire uis_pkg::uis_lin_t linEvent,
    input wire uis_pkg::uis_src_t irqFlag,
    input wire uis_pkg::uis_lin_t linFlag,
    input wire logic txOverFlag,
    input wire logic linIrqFlag,
    input wire uis_pkg::uis_src_t irqIndicator,
    input wire logic irq,
    input wire logic [4:0] rxLevel,
    input wire logic autoRtsEn,
    input wire logic [4:0] rtsLevel,
    input wire logic rtsOut
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_bitClr;
        linFlag.bitError && linClear.bitError && !linEvent.bitError;
    endsequence
    // Break latch survives any clear that lacks its partner bit
    sequence s_brkKeep;
        linIrqFlag && linFlag.linBreak && !(linIrqClear && linClear.linBreak) && !linEvent.linBreak;
    endsequence
    a_ind_mask: assert property (irqIndicator == (irqFlag & irqEnable))
        else $error("indicator differs from flag and enable");
    a_irq_any: assert property (irq == (|irqIndicator))
        else $error("combined request differs from indicators");
    a_bit_set: assert property (linEvent.bitError |=> linFlag.bitError && irqFlag.linBus)
        else $error("bit error flag not raised");
    a_bit_clr: assert property (s_bitClr |=> !linFlag.bitError)
        else $error("bit error flag not cleared");
    a_brk_keep: assert property (s_brkKeep |=> linIrqFlag)
        else $error("LIN flag lost without paired clear");
    a_over_set: assert property (txWrite && !txReady |=> txOverFlag)
        else $error("write when full did not flag overflow");
    a_over_hold: assert property (txOverFlag && !txOverClear |=> txOverFlag)
        else $error("overflow flag dropped without clear");
    // A read restarts the idle count, so a second read cannot meet a new set
    a_tout_clr: assert property (rxRead ##1 rxRead |=> !irqFlag.rxTimeout)
        else $error("timeout flag survived a read");
    a_rts_drop: assert property (autoRtsEn && rxLevel >= rtsLevel |-> ##[1:2] !rtsOut)
        else $error("RTS not withdrawn at fill level");
endmodule
bind uis_uart uis_uart_sva chk (.*);

// file: uis_serial_peer.sv
// Serial peer model: sends frames into the receiver, decodes the transmit line
`timescale 1ns/1ps
module uis_serial_peer #(
    parameter int BIT_CLKS = 48
) (
    input wire logic clk,
    input wire logic txd,
    input wire logic rtsOut,
    input wire logic ctsAllow,
    output logic rxd,
    output logic ctsIn,
    output logic gotValid,
    output logic [7:0] gotByte
);
    initial
    begin
        rxd = 1'h1;
        gotValid = 1'h0;
        gotByte = 8'h00;
    end
    assign ctsIn = ctsAllow;
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'h1, d, 1'h0};
        while (!rtsOut)
            @(posedge clk);
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clk);
            rxd <= f[i];
            repeat (BIT_CLKS - 1) @(posedge clk);
        end
    endtask
    // Samples mid-bit, so a drift of under half a bit is tolerated
    always
    begin
        @(negedge txd);
        repeat (BIT_CLKS / 2) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CLKS) @(posedge clk);
            gotByte[i] <= txd;
        end
        gotValid <= 1'h1;
        @(posedge clk);
        gotValid <= 1'h0;
    end
endmodule

// file: tb.sv
// Self-checking bench for the serial controller interrupt and status block
`timescale 1ns/1ps
module tb;
    logic clk, rst_b, autoRtsEn, autoCtsEn, dmaMode, txWrite, rxRead, ctsChangeClear, txOverClear;
    logic rxOverClear, linIrqClear, dmaFlagClearBit, rs485AddrEvent, ctsAllow, txReady, rxDataValid;
    logic txOverFlag, rxOverFlag, linIrqFlag, irq, rxd, txd, ctsIn, rtsOut, gotValid;
    logic [1:0] functionSelect;
    logic [15:0] baudDiv;
    logic [7:0] txGapDelay, timeoutDelay, txWrData, rxBufferReg, gotByte, b;
    logic [4:0] rxTrigLevel, rtsLevel, rxLevel, txLevel;
    uis_pkg::uis_src_t irqEnable, irqFlag, irqIndicator;
    uis_pkg::uis_line_t lineClear, lineFlag;
    uis_pkg::uis_lin_t linClear, linEvent, linFlag, ev;
    logic [7:0] txQ[$], rxQ[$];
    int errCount, totalChecks, seed;
    uis_uart DUT (.*);
    uis_serial_peer peer (.*);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            errCount++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Strobe stays high across back-to-back calls; caller lowers it
    task automatic wr(input logic [7:0] d);
        txWrite = 1'h1;
        txWrData = d;
        if (txReady)
            txQ.push_back(d);
        step(1);
    endtask
    task automatic drain(input string s);
        txWrite = 1'h0;
        for (int n = 0; n < 20000 && txQ.size() != 0; n++)
            step(1);
        step(60);
        $display("test %s finished", s);
    endtask
    task automatic finalReport();
        $display("checks %0d, mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        #1500000;
        errCount++;
        finalReport();
    end
    always @(posedge clk)
    begin
        if (gotValid)
            check("txByte", gotByte, txQ.pop_front());
        if (rxRead)
            check("rxByte", rxBufferReg, rxQ.pop_front());
    end
    initial
    begin
        seed = 32'h5a65;
        {rst_b, autoCtsEn, dmaMode, txWrite, rxRead, ctsChangeClear, txOverClear, rxOverClear} = '0;
        {linIrqClear, dmaFlagClearBit, rs485AddrEvent, lineClear, linClear, linEvent, txWrData} = '0;
        {autoRtsEn, ctsAllow, irqEnable} = '1;
        functionSelect = uis_pkg::FUNSEL_UART;
        baudDiv = 16'h0002;
        {txGapDelay, timeoutDelay, rxTrigLevel, rtsLevel} = {8'h01, 8'h02, 5'h02, 5'h02};
        step(3);
        rst_b = 1'h1;
        step(1);
        check("reset", {irqFlag, lineFlag, linFlag, txOverFlag, rxOverFlag, linIrqFlag, txd}, 32'h1);
        for (int i = 0; i < 3; i++)
            wr(8'($random(seed)));
        drain("tx");
        check("txEmpty", {irqFlag.txEmpty, irqIndicator.txEmpty, irq}, 32'h7);
        autoCtsEn = 1'h1;
        ctsAllow = 1'h0;
        step(3);
        check("ctsChange", irqFlag.modemWake, 32'h1);
        for (int i = 0; i < 18; i++)
            wr(8'($random(seed)));
        txWrite = 1'h0;
        txOverClear = 1'h0;
        step(1);
        check("full", {txLevel, txReady, txOverFlag}, {25'h0, 5'h10, 2'h1});
        {txOverClear, ctsChangeClear} = 2'h3;
        step(1);
        {txOverClear, ctsChangeClear} = 2'h0;
        step(1);
        check("clears", {txOverFlag, irqFlag.modemWake}, 32'h0);
        ctsAllow = 1'h1;
        drain("overflow");
        for (int i = 0; i < 3; i++)
        begin
            b = 8'($random(seed));
            rxQ.push_back(b);
            peer.send(b);
            if (i == 1)
            begin
                step(60);
                check("rxTrig", {rxLevel, irqFlag.rxAvail, rtsOut}, {25'h0, 5'h02, 2'h2});
                rxRead = 1'h1;
                step(2);
                rxRead = 1'h0;
            end
        end
        for (int n = 0; n < 400 && irqFlag.rxTimeout !== 1'h1; n++)
            step(1);
        check("timeout", {irqFlag.rxTimeout, irqFlag.rxAvail}, 32'h2);
        check("rxValid", rxDataValid, 32'h1);
        rxRead = 1'h1;
        step(1);
        rxRead = 1'h0;
        step(1);
        check("toutClear", irqFlag.rxTimeout, 32'h0);
        check("rxEmpty", rxDataValid, 32'h0);
        for (int i = 0; i < 5; i++)
        begin
            ev = uis_pkg::uis_lin_t'(5'h01 << i);
            linEvent = ev;
            step(1);
            linEvent = '0;
            step(1);
            check("linSet", {linFlag, irqFlag.linBus, linIrqFlag}, {25'h0, ev, 1'h1, ev.linBreak});
            linClear = ev;
            step(1);
            linClear = '0;
            step(1);
            if (ev.linBreak)
            begin
                check("linPair", linIrqFlag, 32'h1);
                {linClear, linIrqClear} = {ev, 1'h1};
                step(1);
                {linClear, linIrqClear} = '0;
                step(1);
            end
            check("linClear", {linFlag, linIrqFlag}, 32'h0);
        end
        for (int m = 0; m < 2; m++)
        begin
            dmaMode = m[0];
            rs485AddrEvent = 1'h1;
            step(1);
            rs485AddrEvent = 1'h0;
            step(1);
            check("lineSet", irqFlag.lineStatus, 32'h1);
            lineClear.addrMatch = 1'h1;
            step(1);
            lineClear = '0;
            step(1);
            check("lineClear", irqFlag.lineStatus, {31'h0, m[0]});
            dmaFlagClearBit = 1'h1;
            step(1);
            dmaFlagClearBit = 1'h0;
            step(1);
            check("dmaClear", irqFlag.lineStatus, 32'h0);
        end
        dmaMode = 1'h0;
        functionSelect = uis_pkg::FUNSEL_LIN;
        wr(8'($random(seed)));
        txWrite = 1'h0;
        step(600);
        check("modeHeld", {txLevel, txd}, {26'h0, 5'h01, 1'h1});
        functionSelect = uis_pkg::FUNSEL_UART;
        drain("mode");
        check("pending", txQ.size() + rxQ.size(), 32'h0);
        finalReport();
    end
endmodule
